// file: sdg_top.sv
/*
  sdg_top: three-channel step and direction generator with APB register file,
  unit tick divider and a masked level interrupt.
  Assumes an APB master on i_clk; step and direction pins feed a power stage.
*/
//
// Contract
// (R1) add rate every tick, msb toggle steps
// (R2) 32-bit accumulator sets step frequency
// (R3) direction equals rate sign bit
// (R4) zero rate clears accumulator, halts steps
// (R5) rate write starts after delay pipeline
// (R6) sign change adds step-to-direction delay
// (R7) stretch step to length plus one
// (R8) software keeps pulse shorter than interval
// (R9) unit logic runs at 25 MHz
// (R10) step rate capped at half unit clock
// (R11) continuous or target count operation
// (R12) counter follows direction, zero by bit
// (R13) target writable, stops, reads remaining
// (R14) compare loads step count in target mode
// (R15) compare match loads next rate
// (R16) configuration holds mode, polarities, enables
// (R17) target reached pulses one clock
// (R18) three independent channels
// (R19) 32-bit counts, counter wraps
`timescale 1ns/1ps
`default_nettype none
module sdg_top
  import sdg_pkg::*;
#(
  parameter int CHANNELS = SDG_CHANNELS,
  parameter int ACC_W = SDG_ACC_W,
  parameter int DLY_W = SDG_DLY_W
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [SDG_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [CHANNELS-1:0] o_step,
  output logic [CHANNELS-1:0] o_dir,
  output logic [CHANNELS-1:0] o_target_irq,
  output logic o_irq
);

  // channel index field of the address
  localparam int CH_LSB = 5;
  localparam int CH_W = 2;

  // tick divider state
  logic [SDG_TICK_CNT_W-1:0] tick_cnt_q; // divider count
  logic tick_q; // one-cycle unit enable

  // apb decode
  logic apb_setup; // first cycle of a transfer
  logic apb_access; // access phase, always completes at once
  logic apb_wr; // write takes effect this edge
  logic addr_hit; // address maps to a register
  logic [CH_W-1:0] ch_sel; // addressed channel
  logic [4:0] ch_off; // offset within a channel block
  logic [31:0] rd_mux; // combinational read value
  logic [31:0] prdata_q; // read data captured in setup
  // pslverr is decoded from the access cycle and needs no flop

  // per channel register storage
  sdg_cfg_s cfg_q [CHANNELS]; // configuration bits
  logic [ACC_W-1:0] next_q [CHANNELS]; // next rate
  logic [ACC_W-1:0] cmp_q [CHANNELS]; // compare value
  logic [DLY_W-1:0] fdel_q [CHANNELS]; // first_step_delay
  logic [DLY_W-1:0] s2d_q [CHANNELS]; // step_to_dir_delay
  logic [DLY_W-1:0] len_q [CHANNELS]; // step_pulse_length

  // write strobes into the channels, one clock wide
  logic [CHANNELS-1:0] rate_wr;
  logic [CHANNELS-1:0] target_wr;
  logic [CHANNELS-1:0] cmp_wr;
  logic [CHANNELS-1:0] zero_wr;

  // channel read-back
  logic [ACC_W-1:0] rate_rd [CHANNELS];
  logic [ACC_W-1:0] count_rd [CHANNELS];
  logic [ACC_W-1:0] remain_rd [CHANNELS];
  logic [CHANNELS-1:0] hit;

  // interrupt registers
  logic [CHANNELS-1:0] irq_stat_q; // sticky target reached
  logic [CHANNELS-1:0] irq_mask_q; // one enables the bit
  logic [CHANNELS-1:0] irq_clr; // write-one-to-clear
  logic irq_q; // registered level output

  // true when the address selects a given register of a given channel
  function automatic logic reg_sel(input logic [SDG_ADDR_W-1:0] addr,
                                   input int ch,
                                   input logic [4:0] off);
    reg_sel = (addr[CH_LSB +: CH_W] == CH_W'(ch)) && (addr[4:0] == off);
  endfunction

  // true for an address that is a defined register
  function automatic logic addr_valid(input logic [SDG_ADDR_W-1:0] addr);
    addr_valid = 1'b0;
    if (addr == SDG_REG_IRQ_STAT || addr == SDG_REG_IRQ_MASK)
      addr_valid = 1'b1;
    else if ((addr[CH_LSB +: CH_W] < CH_W'(CHANNELS)) && (addr[1:0] == 2'b00)
             && (addr[SDG_ADDR_W-1:CH_LSB+CH_W] == '0))
      addr_valid = 1'b1;
  endfunction

  // the unit runs on this enable rather than a derived clock, so every
  // flop stays on i_clk and no clock crossing is needed
  // unit tick divider: one enable every five system clocks
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == SDG_TICK_CNT_W'(SDG_TICK_DIV - 1))
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1; // R9
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // apb phase decode; the slave never inserts wait states
  // a transfer to an unmapped address still completes, with an error flag
  assign apb_setup = i_psel && !i_penable;
  assign apb_access = i_psel && i_penable;
  assign apb_wr = apb_access && i_pwrite;
  assign ch_sel = i_paddr[CH_LSB +: CH_W];
  assign ch_off = i_paddr[4:0];
  assign addr_hit = addr_valid(i_paddr);

  // the read value is captured one cycle early, in setup, which keeps
  // prdata on a flop at the cost of sampling count and remaining there
  // read mux; reserved bits read as zero
  always_comb
  begin
    rd_mux = '0;
    if (i_paddr == SDG_REG_IRQ_STAT)
      rd_mux[CHANNELS-1:0] = irq_stat_q;
    else if (i_paddr == SDG_REG_IRQ_MASK)
      rd_mux[CHANNELS-1:0] = irq_mask_q;
    else if (addr_hit)
    begin
      case (ch_off)
        SDG_REG_CFG:
          rd_mux[SDG_CFG_DIR_POL:SDG_CFG_ENABLE] = cfg_q[ch_sel];
        SDG_REG_RATE:
          rd_mux = rate_rd[ch_sel];
        SDG_REG_NEXT:
          rd_mux = next_q[ch_sel];
        SDG_REG_TARGET:
          rd_mux = remain_rd[ch_sel]; // R13
        SDG_REG_COMPARE:
          rd_mux = cmp_q[ch_sel];
        SDG_REG_COUNT:
          rd_mux = count_rd[ch_sel]; // R12
        SDG_REG_DELAY:
          rd_mux = {s2d_q[ch_sel], fdel_q[ch_sel]};
        SDG_REG_LENGTH:
          rd_mux[DLY_W-1:0] = len_q[ch_sel];
        default:
          rd_mux = '0;
      endcase
    end
  end

  // read data captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prdata_q <= '0;
    else if (apb_setup && !i_pwrite)
      prdata_q <= rd_mux;
  end

  assign o_prdata = prdata_q;
  assign o_pready = apb_access;
  // unmapped addresses answer with an error in the same access cycle
  assign o_pslverr = apb_access && !addr_hit;

  // channel register writes; zeroing is a strobe and is not stored
  // a write to the count register is accepted and ignored: it is read-only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        cfg_q[c] <= SDG_CFG_RESET;
        next_q[c] <= '0;
        cmp_q[c] <= '0;
        fdel_q[c] <= '0;
        s2d_q[c] <= '0;
        len_q[c] <= '0;
      end
    end
    else if (apb_wr)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        if (reg_sel(i_paddr, c, SDG_REG_CFG))
          cfg_q[c] <= i_pwdata[SDG_CFG_DIR_POL:SDG_CFG_ENABLE]; // R16
        if (reg_sel(i_paddr, c, SDG_REG_NEXT))
          next_q[c] <= i_pwdata; // R15
        if (reg_sel(i_paddr, c, SDG_REG_COMPARE))
          cmp_q[c] <= i_pwdata; // R14
        if (reg_sel(i_paddr, c, SDG_REG_DELAY))
        begin
          fdel_q[c] <= i_pwdata[DLY_W-1:0]; // R5
          s2d_q[c] <= i_pwdata[SDG_DELAY_S2D_LSB +: DLY_W]; // R6
        end
        if (reg_sel(i_paddr, c, SDG_REG_LENGTH))
          len_q[c] <= i_pwdata[DLY_W-1:0]; // R7
      end
    end
  end

  // write strobes that act inside the channels
  always_comb
  begin
    rate_wr = '0;
    target_wr = '0;
    cmp_wr = '0;
    zero_wr = '0;
    for (int c = 0; c < CHANNELS; c++)
    begin
      rate_wr[c] = apb_wr && reg_sel(i_paddr, c, SDG_REG_RATE); // R5
      target_wr[c] = apb_wr && reg_sel(i_paddr, c, SDG_REG_TARGET); // R13
      cmp_wr[c] = apb_wr && reg_sel(i_paddr, c, SDG_REG_COMPARE);
      zero_wr[c] = apb_wr && reg_sel(i_paddr, c, SDG_REG_CFG)
                   && i_pwdata[SDG_CFG_ZERO]; // R12
    end
  end

  // three independent generators
  // each channel keeps its own accumulator, counter and target
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_ch
      sdg_channel #(
        .ACC_W(ACC_W),
        .DLY_W(DLY_W)
      ) u_ch (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick_q),
        .i_cfg(cfg_q[g]),
        .i_rate_wr(rate_wr[g]),
        .i_target_wr(target_wr[g]),
        .i_cmp_wr(cmp_wr[g]),
        .i_zero(zero_wr[g]),
        .i_wdata(i_pwdata),
        .i_next_rate(next_q[g]),
        .i_compare(cmp_q[g]),
        .i_first_step_delay(fdel_q[g]),
        .i_step_to_dir_delay(s2d_q[g]),
        .i_step_pulse_length(len_q[g]),
        .o_step(o_step[g]),
        .o_dir(o_dir[g]),
        .o_target_hit(hit[g]),
        .o_rate(rate_rd[g]),
        .o_count(count_rd[g]),
        .o_remaining(remain_rd[g])
      ); // R18
    end
  endgenerate

  // per channel target pulses leave directly, one clock each
  assign o_target_irq = hit; // R17

  // interrupt clear strobe from a status write
  // only bits that exist are cleared; upper write data bits are ignored
  assign irq_clr = (apb_wr && (i_paddr == SDG_REG_IRQ_STAT))
                   ? i_pwdata[CHANNELS-1:0] : '0;

  // sticky status: a hit in the clearing cycle wins over the clear
  // so that no target event can be lost to a badly timed clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | hit;
  end

  // interrupt mask register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_mask_q <= '0;
    else if (apb_wr && (i_paddr == SDG_REG_IRQ_MASK))
      irq_mask_q <= i_pwdata[CHANNELS-1:0];
  end

  // level interrupt, built from the next status so it changes with the status yet leaves a flop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |((irq_stat_q & ~irq_clr | hit) & irq_mask_q);
  end

  assign o_irq = irq_q;

  // the tick comes exactly every fifth clock
  AST_TICK_PERIOD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
    tick_q |=> !tick_q [*4] ##1 tick_q) else $error("unit tick period wrong");

  // a target hit is always recorded in the sticky status
  AST_STAT_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    |hit |=> (irq_stat_q & $past(hit)) == $past(hit)) else $error("hit not latched");

  // the interrupt pin is the registered or of the unmasked status bits
  AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    1'b1 |=> o_irq == |(irq_stat_q & $past(irq_mask_q)))
    else $error("interrupt level wrong");

  // writing ones clears status bits when no hit lands in the same clock
  AST_STAT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    apb_wr && (i_paddr == SDG_REG_IRQ_STAT) && !(|hit) |=>
    (irq_stat_q & $past(i_pwdata[CHANNELS-1:0])) == '0) else $error("status not cleared");

  // a refused read returns zero so no stale register value leaks out
  AST_REFUSED_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
    o_pslverr && !i_pwrite |-> o_prdata == '0) else $error("refused read not zero");

endmodule
`default_nettype wire

// file: sdg_pkg.sv
/*
  sdg_pkg: constants, register map, field layout, channel state encoding and
  the configuration carrier shared by the step/direction generator files.
  Assumes a single 125 MHz system clock and an APB slave register map.
*/
package sdg_pkg;

  // channel count and datapath widths
  localparam int SDG_CHANNELS = 3;
  localparam int SDG_ACC_W = 32;
  localparam int SDG_DLY_W = 16;
  localparam int SDG_ADDR_W = 8;

  // clock periods; the unit tick is derived from both
  localparam int SDG_CLK_PERIOD_NS = 8;
  localparam int SDG_UNIT_PERIOD_NS = 40;
  localparam int SDG_TICK_DIV = SDG_UNIT_PERIOD_NS / SDG_CLK_PERIOD_NS;
  localparam int SDG_TICK_CNT_W = 3;

  // per channel register block: channel index in address bits 6:5
  localparam logic [4:0] SDG_REG_CFG = 5'h00;
  localparam logic [4:0] SDG_REG_RATE = 5'h04;
  localparam logic [4:0] SDG_REG_NEXT = 5'h08;
  localparam logic [4:0] SDG_REG_TARGET = 5'h0c;
  localparam logic [4:0] SDG_REG_COMPARE = 5'h10;
  localparam logic [4:0] SDG_REG_COUNT = 5'h14;
  localparam logic [4:0] SDG_REG_DELAY = 5'h18;
  localparam logic [4:0] SDG_REG_LENGTH = 5'h1c;
  // global interrupt registers
  localparam logic [7:0] SDG_REG_IRQ_STAT = 8'h60;
  localparam logic [7:0] SDG_REG_IRQ_MASK = 8'h64;

  // configuration field positions
  localparam int SDG_CFG_ENABLE = 0;
  localparam int SDG_CFG_TARGET = 1;
  localparam int SDG_CFG_CMP_EN = 2;
  localparam int SDG_CFG_STEP_POL = 3;
  localparam int SDG_CFG_DIR_POL = 4;
  localparam int SDG_CFG_ZERO = 5;
  localparam int SDG_DELAY_S2D_LSB = 16;

  // configuration carried from the register file into a channel
  typedef struct packed {
    logic dir_pol;
    logic step_pol;
    logic cmp_en;
    logic target_mode;
    logic enable;
  } sdg_cfg_s;

  localparam sdg_cfg_s SDG_CFG_RESET = 5'h00;

  // channel run state
  typedef enum logic [2:0] {
    SDG_IDLE = 3'b001,
    SDG_WAIT = 3'b010,
    SDG_RUN = 3'b100
  } sdg_state_e;

endpackage

// file: sdg_channel.sv
/*
  sdg_channel: one step/direction generator with phase accumulator, start
  delay, pipeline, pulse stretcher, step counter, target and compare logic.
  Assumes i_tick is a one-cycle enable at the unit rate and that register
  write strobes last one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdg_channel
  import sdg_pkg::*;
#(
  parameter int ACC_W = SDG_ACC_W,
  parameter int DLY_W = SDG_DLY_W
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire sdg_cfg_s i_cfg,
  input wire logic i_rate_wr,
  input wire logic i_target_wr,
  input wire logic i_cmp_wr,
  input wire logic i_zero,
  input wire logic [ACC_W-1:0] i_wdata,
  input wire logic [ACC_W-1:0] i_next_rate,
  input wire logic [ACC_W-1:0] i_compare,
  input wire logic [DLY_W-1:0] i_first_step_delay,
  input wire logic [DLY_W-1:0] i_step_to_dir_delay,
  input wire logic [DLY_W-1:0] i_step_pulse_length,
  output logic o_step,
  output logic o_dir,
  output logic o_target_hit,
  output logic [ACC_W-1:0] o_rate,
  output logic [ACC_W-1:0] o_count,
  output logic [ACC_W-1:0] o_remaining
);

  sdg_state_e state_q; // run state
  logic [ACC_W-1:0] acc_q; // phase accumulator
  logic [ACC_W-1:0] rate_q; // active chan_rate_constant
  logic [ACC_W-1:0] acc_sum; // accumulator plus rate
  logic [DLY_W:0] dly_q; // start delay down counter, one bit wider for the sum
  logic [DLY_W:0] dly_load; // first_step_delay plus optional step_to_dir_delay
  logic [ACC_W-1:0] count_q; // signed step counter
  logic [ACC_W-1:0] count_step; // counter after one step
  logic [ACC_W-1:0] remaining_q; // steps still to go in target mode
  logic last_step_q; // previous tick stepped
  logic step_raw; // internal one-clock step
  logic tgt_block; // target mode with nothing left
  logic [1:0] pipe_q; // two-tick processing pipeline
  logic [DLY_W-1:0] str_cnt_q; // stretcher down counter
  logic str_act_q; // stretched pulse active
  logic hit_q; // target reached pulse

  // step detection: msb toggle of the accumulator, capped to every other tick
  assign acc_sum = acc_q + rate_q; // R2
  assign tgt_block = i_cfg.target_mode && (remaining_q == '0);
  assign step_raw = i_tick && (state_q == SDG_RUN) && i_cfg.enable
                    && (acc_sum[ACC_W-1] != acc_q[ACC_W-1]) // R1
                    && !last_step_q && !tgt_block; // R10 R13 R11
  assign count_step = rate_q[ACC_W-1] ? count_q - 1'b1 : count_q + 1'b1;
  // a sign change adds the step-to-direction hold to the start delay
  assign dly_load = {1'b0, i_first_step_delay}
                  + ((i_wdata[ACC_W-1] != rate_q[ACC_W-1]) ? {1'b0, i_step_to_dir_delay}
                                                           : {(DLY_W+1){1'b0}}); // R6 R5

  // rate, accumulator and run state; a bus write beats the automatic reload
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= SDG_IDLE;
      acc_q <= '0;
      rate_q <= '0;
      dly_q <= '0;
    end
    else if (i_rate_wr)
    begin
      rate_q <= i_wdata;
      dly_q <= dly_load; // R5
      if (i_wdata == '0)
      begin
        acc_q <= '0; // R4
        state_q <= SDG_IDLE;
      end
      else
        state_q <= SDG_WAIT;
    end
    else if (i_tick)
    begin
      case (state_q)
        SDG_WAIT:
        begin
          if (dly_q == '0)
            state_q <= SDG_RUN;
          else
            dly_q <= dly_q - 1'b1;
        end
        SDG_RUN:
        begin
          // accumulator holds still while disabled or the target is used up
          if (i_cfg.enable && !tgt_block)
            acc_q <= acc_sum; // R1
          if (step_raw && i_cfg.cmp_en && (count_step == i_compare))
            rate_q <= i_next_rate; // R15
        end
        default:
          state_q <= state_q;
      endcase
    end
  end

  // step counter; zeroing wins over a simultaneous step
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_q <= '0;
    else if (i_zero)
      count_q <= '0; // R12
    else if (step_raw)
      count_q <= count_step; // R12 R19
  end

  // remaining target steps and the target reached pulse
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      remaining_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      hit_q <= step_raw && i_cfg.target_mode && (remaining_q == 1); // R17
      if (i_target_wr)
        remaining_q <= i_wdata; // R13
      else if (i_cmp_wr && i_cfg.target_mode)
        remaining_q <= i_wdata; // R14
      else if (step_raw && i_cfg.target_mode)
        remaining_q <= remaining_q - 1'b1; // R13
    end
  end

  // two-tick pipeline then the stretcher, held for length plus one ticks
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last_step_q <= 1'b0;
      pipe_q <= '0;
      str_cnt_q <= '0;
      str_act_q <= 1'b0;
    end
    else if (i_tick)
    begin
      last_step_q <= step_raw;
      pipe_q <= {pipe_q[0], step_raw}; // R5
      if (pipe_q[1])
      begin
        str_act_q <= 1'b1; // R7
        str_cnt_q <= i_step_pulse_length;
      end
      else if (str_cnt_q != '0)
        str_cnt_q <= str_cnt_q - 1'b1;
      else
        str_act_q <= 1'b0;
    end
  end

  // output flops with polarity; direction follows the rate sign
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_step <= 1'b0;
      o_dir <= 1'b0;
    end
    else
    begin
      o_step <= str_act_q ^ i_cfg.step_pol; // R16
      o_dir <= rate_q[ACC_W-1] ^ i_cfg.dir_pol; // R3 R16
    end
  end

  assign o_target_hit = hit_q;
  assign o_rate = rate_q;
  assign o_count = count_q;
  assign o_remaining = remaining_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ZERO_HALT: assert property (i_rate_wr && (i_wdata == '0) |=> // R4
    (acc_q == '0) && (state_q == SDG_IDLE) && !step_raw) else $error("zero rate did not halt");
  AST_MAX_RATE: assert property (step_raw |=> !step_raw [*8]) // R10
    else $error("steps closer than two unit ticks");
  AST_DIR_SIGN: assert property (!$changed(rate_q) && !$changed(i_cfg) |=> // R3
    o_dir == ($past(rate_q[ACC_W-1]) ^ $past(i_cfg.dir_pol)))
    else $error("direction not rate sign");
  AST_COUNT_STEP: assert property (step_raw && !i_zero |=> // R12
    count_q == $past(count_step)) else $error("counter missed a step");
  AST_TARGET_STOP: assert property (tgt_block && !i_target_wr && !i_cmp_wr // R13
    && !i_rate_wr |=> (remaining_q == '0) && $stable(acc_q))
    else $error("target count left zero or accumulator moved");
  AST_HIT_PULSE: assert property (o_target_hit |-> // R17
    !$past(o_target_hit) ##1 !o_target_hit) else $error("target pulse not one clock");
  AST_PIPE_DELAY: assert property (step_raw |-> ##[1:15] str_act_q) // R5 R7
    else $error("stretcher not started after step");

endmodule
`default_nettype wire

// file: sdg_stage_model.sv
/*
  sdg_stage_model: behavioural power stage that counts step pulses per
  channel and measures the stepping width of channel 0.
  Assumes active-high step pulses and direction polarity left at 0.
*/
`timescale 1ns/1ps
`default_nettype none
module sdg_stage_model
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_step,
  input wire logic [2:0] i_dir,
  output logic [31:0] o_pos [3],
  output logic [31:0] o_width
);
  // previous step level, for edge detection
  logic [2:0] prev_q;
  // running high time of channel 0, in clocks
  logic [31:0] run_q;

  // count one position per rising step edge; a pulse too long to end
  // before the next step merges and is counted once, as a real stage would
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_q <= 3'h0;
      run_q <= 32'h0;
      o_width <= 32'h0;
      for (int c = 0; c < 3; c++)
        o_pos[c] <= 32'h0;
    end
    else
    begin
      prev_q <= i_step;
      for (int c = 0; c < 3; c++)
        if (i_step[c] && !prev_q[c])
          o_pos[c] <= i_dir[c] ? o_pos[c] - 32'h1 : o_pos[c] + 32'h1;
      // width is latched on the falling edge of channel 0
      if (i_step[0])
        run_q <= run_q + 32'h1;
      else if (prev_q[0])
      begin
        o_width <= run_q;
        run_q <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_step_direction_generator.sv
/*
  tb_step_direction_generator: self-checking bench for the three-channel
  step and direction generator, reached over APB.
  Assumes sdg_top with its zero-wait APB slave and a 5-clock unit tick.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_step_direction_generator
  import sdg_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, width, hold;
  logic pready, pslverr, irq, err;
  logic [2:0] step, dir, thit;
  logic [31:0] pos [3];
  int fail_count = 0, cmp_count = 0, irq_pulses = 0;

  sdg_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_step(step), .o_dir(dir),
    .o_target_irq(thit), .o_irq(irq));
  sdg_stage_model stage_u (.i_clk(clk), .i_rst_n(rst_n), .i_step(step), .i_dir(dir),
    .o_pos(pos), .o_width(width));

  // 125 MHz system clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  // count one-clock target pulses of channel 2
  always @(posedge clk)
    if (thit[2] === 1'b1)
      irq_pulses++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // reset values and a refused access
  task automatic t_reset_map();
    rdc(8'h00, 32'h0);
    rdc(8'h14, 32'h0);
    apb(1'b0, 8'h70, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  // channel 0 free running, stretched pulse, halt on zero rate
  task automatic t_free_run();
    wr(8'h1c, 32'h2);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h10000000);
    repeat (800) @(posedge clk);
    wr(8'h04, 32'h0);
    repeat (100) @(posedge clk);
    rdc(8'h14, pos[0]);
    check({31'h0, pos[0] > 32'd15}, 32'h1);
    check(width, 32'd15);
    hold = pos[0];
    repeat (200) @(posedge clk);
    check(pos[0], hold);
    rdc(8'h04, 32'h0);
  endtask

  // channel 1: compare loads next rate, then reverse, polarity, zeroing
  task automatic t_compare_dir();
    int n;
    wr(8'h38, 32'h00040000);
    wr(8'h20, 32'h5);
    wr(8'h30, 32'h2);
    wr(8'h28, 32'h10000000);
    wr(8'h24, 32'h20000000);
    repeat (300) @(posedge clk);
    rdc(8'h24, 32'h10000000);
    // stop before reversing so no step in flight meets the new direction
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h0);
    repeat (100) @(posedge clk);
    wr(8'h24, 32'he0000000);
    // the sign change adds four ticks of hold: the first step shows 38 to 42
    // clocks after the write, the spread being the phase of the unit tick
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (step[1] !== 1'b1 && n < 100);
    check({31'h0, (n >= 38) && (n <= 42)}, 32'h1);
    repeat (560) @(posedge clk);
    check({31'h0, dir[1]}, 32'h1);
    // freeze first so steps still in the pipe leave while direction is negative
    wr(8'h20, 32'h0);
    repeat (100) @(posedge clk);
    wr(8'h24, 32'h0);
    repeat (100) @(posedge clk);
    rdc(8'h34, pos[1]);
    check({31'h0, dir[1]}, 32'h0);
    // direction and step polarity both invert their idle levels
    wr(8'h20, 32'h19);
    repeat (4) @(posedge clk);
    check({31'h0, dir[1]}, 32'h1);
    check({31'h0, step[1]}, 32'h1);
    wr(8'h20, 32'h21);
    rdc(8'h34, 32'h0);
    rdc(8'h14, pos[0]);
  endtask

  // channel 2 target mode with interrupt, reload through compare
  task automatic t_target_irq();
    int n;
    wr(8'h64, 32'h4);
    wr(8'h40, 32'h3);
    wr(8'h4c, 32'h3);
    wr(8'h44, 32'h40000000);
    n = 0;
    while (irq !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, irq}, 32'h1);
    repeat (200) @(posedge clk);
    check(pos[2], 32'h3);
    check(irq_pulses, 32'h1);
    rdc(8'h4c, 32'h0);
    rdc(8'h54, 32'h3);
    rdc(8'h60, 32'h4);
    wr(8'h60, 32'h4);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdc(8'h60, 32'h0);
    wr(8'h50, 32'h2);
    repeat (300) @(posedge clk);
    check(pos[2], 32'h5);
    check(irq_pulses, 32'h2);
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_map();
    t_free_run();
    t_compare_dir();
    t_target_irq();
    wrap_up();
  end

  // watchdog well beyond the expected run of about 3000 clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
